/* inc/mic_pkg.sv */
// mic_pkg: register map, field positions and encodings of the interrupt control unit
package mic_pkg;
   localparam int         MIC_AW          = 8;
   localparam int         MIC_DW          = 8;
   localparam int         MIC_NSRC        = 23;
   // register offsets
   localparam logic [7:0] MIC_OFF_REQ_A   = 8'h02;
   localparam logic [7:0] MIC_OFF_REQ_B   = 8'h03;
   localparam logic [7:0] MIC_OFF_REQ_C   = 8'h04;
   localparam logic [7:0] MIC_OFF_EN_A    = 8'h05;
   localparam logic [7:0] MIC_OFF_EN_B    = 8'h06;
   localparam logic [7:0] MIC_OFF_EN_C    = 8'h07;
   localparam logic [7:0] MIC_OFF_POL     = 8'h37;
   // reset values
   localparam logic [7:0] MIC_RST_REQ     = 8'h00;
   localparam logic [7:0] MIC_RST_EN      = 8'h00;
   localparam logic [7:0] MIC_RST_POL     = 8'h00;
   // used bits of the third bank and of the polarity register
   localparam logic [7:0] MIC_MASK_C      = 8'h7f;
   localparam logic [7:0] MIC_MASK_POL    = 8'h03;
   // field positions in the flat 23-bit source vector (bank a at 0, b at 8, c at 16) and in the polarity register
   localparam int         MIC_BIT_LINE0   = 2;
   localparam int         MIC_BIT_LINE1   = 3;
   localparam int         MIC_POL_LINE0   = 0;
   localparam int         MIC_POL_LINE1   = 1;
   // reset, break and first source vectors, priorities of reset and of the first source
   localparam logic [15:0] MIC_VEC_RESET  = 16'hfffa;
   localparam logic [15:0] MIC_VEC_BRK    = 16'hffca;
   localparam logic [15:0] MIC_VEC_FIRST  = 16'hfff8;
   localparam logic [4:0]  MIC_PRIO_RESET = 5'h03;
   localparam logic [4:0]  MIC_PRIO_FIRST = 5'h04;

   typedef enum logic [2:0] {
      MIC_IDLE    = 3'b001,
      MIC_PENDING = 3'b010,
      MIC_ACK     = 3'b100
   } mic_state_t;
endpackage : mic_pkg

/* verilog/mic_ctrl.sv */
// mic_ctrl: maskable interrupt control unit with request, enable and polarity registers
//
// Functional notes
// R1 - 23 maskable sources, one software break and reset as non-maskable vector.
// R2 - each source has request flag, enable flag; with global mask they gate service.
// R3 - a source's event sets its request flag to one.
// R4 - request flag clears on service or when software writes zero.
// R5 - software writing one leaves a request flag unchanged; cannot set it.
// R6 - polling ignores requests whose enable is zero.
// R7 - bank a: usb, sof, line0, line1, dma0, dma1, serial1 rx, serial1 tx.
// R8 - bank b: serial1 err, serial2 rx, serial2 tx, serial2 err, timers x,y,1,2.
// R9 - bank c: timer3, counter pins 0,1, sync serial, host in full, out empty, key.
// R10 - bit 7 of request bank c is reserved and reads zero.
// R11 - enable bank a mirrors request bank a, one enables.
// R12 - request flag reads one when pending, zero otherwise.
// R13 - reset clears request, enable and polarity registers.
// R14 - separate register selects active edge of external lines.
// R15 - reset ranks priority 3 with vector at fffa low, fffb high.
// R16 - before each instruction, request when flag and enable set and mask clear.
// R17 - servicing clears that request flag and sets the global mask.
// R18 - polarity bit zero selects falling edge, one selects rising edge.
// R19 - enable banks b and c mirror request banks b and c.
// R20 - events are captured regardless of enable and held until cleared.
`timescale 1ns/1ps
`default_nettype none
module mic_ctrl
   import mic_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   // register port
   input  wire logic [MIC_AW-1:0]   regAddr,
   input  wire logic [MIC_DW-1:0]   regWdata,
   input  wire logic                regWrite,
   input  wire logic                regRead,
   output logic      [MIC_DW-1:0]   regRdata,
   // peripheral event pulses; bits 2 and 3 unused, lines come as levels
   input  wire logic [MIC_NSRC-1:0] srcEvent,
   input  wire logic                externalLine0,
   input  wire logic                externalLine1,
   // core side
   input  wire logic                pollStrobe,
   input  wire logic                serviceAck,
   input  wire logic                softBreak,
   input  wire logic                returnFromIrq,
   output logic                     serviceReq,
   output logic      [4:0]          serviceSrc,
   output logic      [15:0]         serviceVector,
   output logic                     globalMask,
   output logic                     resetVectorValid,
   output logic      [15:0]         resetVector,
   output logic      [4:0]          resetPriority
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // lowest-numbered pending source has the highest priority
   function automatic logic [4:0] mic_first(input logic [MIC_NSRC-1:0] v);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = MIC_NSRC - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction : mic_first

   function automatic logic mic_hit(input logic [MIC_AW-1:0] a, input logic [7:0] off);
      return a == off;
   endfunction : mic_hit

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [MIC_NSRC-1:0] reqFlags_r;
   logic [MIC_NSRC-1:0] reqFlags_nxt;
   logic [MIC_NSRC-1:0] enFlags_r;
   logic [7:0]          edgePol_r;
   logic [1:0]          lineLast_r;
   logic [MIC_NSRC-1:0] evAll;
   logic [MIC_NSRC-1:0] swClr;
   logic [MIC_NSRC-1:0] svcClr;
   logic [MIC_NSRC-1:0] seenReq;
   logic [1:0]          lineNow;
   logic [1:0]          lineEdge;
   mic_state_t          state_r;
   logic [4:0]          srcSel_r;

   assign lineNow = {externalLine1, externalLine0};

   // edge detect per external line, direction from polarity register
   generate
      for (genvar g = 0; g < 2; g++)
      begin : gLine
         // zero: falling, one: rising [R18]
         assign lineEdge[g] = edgePol_r[g] ? (lineNow[g] & ~lineLast_r[g])
                                            : (~lineNow[g] & lineLast_r[g]);
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (rst)
         lineLast_r <= 2'h0;
      else
         lineLast_r <= lineNow;
   end

   always_comb
   begin
      evAll                 = srcEvent;
      evAll[MIC_BIT_LINE0]  = lineEdge[MIC_POL_LINE0];
      evAll[MIC_BIT_LINE1]  = lineEdge[MIC_POL_LINE1];
   end

   // software write of zero clears, one has no effect [R4] [R5]
   always_comb
   begin
      swClr = '0;
      if (regWrite)
      begin
         if (mic_hit(regAddr, MIC_OFF_REQ_A))
            swClr[7:0]   = ~regWdata;
         if (mic_hit(regAddr, MIC_OFF_REQ_B))
            swClr[15:8]  = ~regWdata;
         if (mic_hit(regAddr, MIC_OFF_REQ_C))
            swClr[22:16] = ~regWdata[6:0];
      end
   end

   always_comb
   begin
      svcClr = '0;
      if (state_r == MIC_ACK)
         svcClr[srcSel_r] = 1'b1;
   end

   // event wins over a clear in the same cycle; enable plays no part [R3] [R20]
   assign reqFlags_nxt = (reqFlags_r & ~swClr & ~svcClr) | evAll;

   always_ff @(posedge clk)
   begin
      if (rst)
         reqFlags_r <= {MIC_RST_REQ[6:0], MIC_RST_REQ, MIC_RST_REQ}; // [R13]
      else
         reqFlags_r <= reqFlags_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         enFlags_r <= {MIC_RST_EN[6:0], MIC_RST_EN, MIC_RST_EN}; // [R13]
      else if (regWrite)
      begin
         if (mic_hit(regAddr, MIC_OFF_EN_A))
            enFlags_r[7:0]   <= regWdata;        // [R11]
         if (mic_hit(regAddr, MIC_OFF_EN_B))
            enFlags_r[15:8]  <= regWdata;        // [R19]
         if (mic_hit(regAddr, MIC_OFF_EN_C))
            enFlags_r[22:16] <= regWdata[6:0];   // [R19]
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         edgePol_r <= MIC_RST_POL; // [R13]
      else if (regWrite && mic_hit(regAddr, MIC_OFF_POL))
         edgePol_r <= regWdata & MIC_MASK_POL; // [R14]
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path, data valid the cycle after the strobe

   always_ff @(posedge clk)
   begin
      if (rst)
         regRdata <= 8'h00;
      else if (regRead)
      begin
         case (regAddr)
            MIC_OFF_REQ_A: regRdata <= reqFlags_r[7:0];            // [R12] [R7]
            MIC_OFF_REQ_B: regRdata <= reqFlags_r[15:8];           // [R8]
            MIC_OFF_REQ_C: regRdata <= {1'b0, reqFlags_r[22:16]};  // [R9] [R10]
            MIC_OFF_EN_A:  regRdata <= enFlags_r[7:0];
            MIC_OFF_EN_B:  regRdata <= enFlags_r[15:8];
            MIC_OFF_EN_C:  regRdata <= {1'b0, enFlags_r[22:16]};
            MIC_OFF_POL:   regRdata <= edgePol_r;
            default:       regRdata <= 8'h00;
         endcase
      end
      else
         regRdata <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // polling and service handshake

   assign seenReq = reqFlags_r & enFlags_r; // [R2] [R6]

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r  <= MIC_IDLE;
         srcSel_r <= 5'h00;
      end
      else
      begin
         case (state_r)
            MIC_IDLE:
               // sampled only at instruction boundaries [R16]
               if (pollStrobe && !globalMask && |seenReq)
               begin
                  state_r  <= MIC_PENDING;
                  srcSel_r <= mic_first(seenReq);
               end
            MIC_PENDING:
               if (serviceAck)
                  state_r <= MIC_ACK;
            MIC_ACK:
               state_r <= MIC_IDLE;
            default:
               state_r <= MIC_IDLE;
         endcase
      end
   end

   // mask set on service or break, cleared by return [R17]
   always_ff @(posedge clk)
   begin
      if (rst)
         globalMask <= 1'b1;
      else if ((state_r == MIC_PENDING && serviceAck) || softBreak)
         globalMask <= 1'b1;
      else if (returnFromIrq)
         globalMask <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         resetVectorValid <= 1'b0;
      else
         resetVectorValid <= 1'b1;
   end

   // handler vector: two bytes per priority step below fff8 [R1]
   always_ff @(posedge clk)
   begin
      if (rst)
         serviceVector <= MIC_VEC_RESET;
      else if (softBreak)
         serviceVector <= MIC_VEC_BRK;
      else
         serviceVector <= MIC_VEC_FIRST - {10'h000, srcSel_r, 1'b0};
   end

   assign serviceReq    = (state_r == MIC_PENDING);
   assign serviceSrc    = srcSel_r;
   assign resetVector   = MIC_VEC_RESET;  // [R15]
   assign resetPriority = MIC_PRIO_RESET; // [R15]

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic [MIC_NSRC-1:0] seenLast_r;

   // polled vector of the cycle before; srcSel_r moves at the same edge as the request
   always_ff @(posedge clk)
   begin
      if (rst)
         seenLast_r <= '0;
      else
         seenLast_r <= seenReq;
   end

   AST_SET_BY_EVENT: assert property (@(posedge clk) disable iff (rst) // [R3]
      srcEvent[0] |=> reqFlags_r[0])
      else $error("event did not set flag");

   AST_SW_ONE_NOSET: assert property (@(posedge clk) disable iff (rst) // [R5]
      regWrite && regAddr == MIC_OFF_REQ_A && !reqFlags_r[5] && !srcEvent[5]
      |=> !reqFlags_r[5])
      else $error("software set a request flag");

   AST_SW_ZERO_CLR: assert property (@(posedge clk) disable iff (rst) // [R4]
      regWrite && regAddr == MIC_OFF_REQ_B && !regWdata[4] && !srcEvent[12]
      |=> !reqFlags_r[12])
      else $error("write of zero did not clear");

   AST_RES_C7: assert property (@(posedge clk) disable iff (rst) // [R10]
      $past(regRead) && $past(regAddr) == MIC_OFF_REQ_C |-> !regRdata[7])
      else $error("reserved bit read as one");

   AST_MASKED_NO_REQ: assert property (@(posedge clk) disable iff (rst) // [R16]
      state_r == MIC_IDLE && globalMask |=> !serviceReq)
      else $error("request raised while masked");

   AST_SEL_ENABLED: assert property (@(posedge clk) disable iff (rst) // [R6]
      $rose(serviceReq) |-> seenLast_r[srcSel_r])
      else $error("disabled source selected");

   // the flag drops one cycle after the ack edge, unless an event lands in that cycle
   AST_SVC_CLEARS: assert property (@(posedge clk) disable iff (rst) // [R17]
      serviceReq && serviceAck && !srcEvent[srcSel_r]
      |=> globalMask ##1 !reqFlags_r[srcSel_r] || $past(evAll[srcSel_r]))
      else $error("service did not clear flag or set mask");

   AST_RESET_ZERO: assert property (@(posedge clk) // [R13]
      rst |=> reqFlags_r == '0 && enFlags_r == '0 && edgePol_r == 8'h00)
      else $error("registers not zero after reset");

   AST_HOLD: assert property (@(posedge clk) disable iff (rst) // [R20]
      reqFlags_r[20] && !swClr[20] && !svcClr[20] |=> reqFlags_r[20])
      else $error("request flag lost");

   AST_LINE_FALL: assert property (@(posedge clk) disable iff (rst) // [R18]
      !edgePol_r[MIC_POL_LINE0] && lineLast_r[0] && !externalLine0
      |=> reqFlags_r[MIC_BIT_LINE0])
      else $error("falling edge on line 0 missed");

   AST_LINE_RISE: assert property (@(posedge clk) disable iff (rst) // [R18]
      edgePol_r[MIC_POL_LINE1] && !lineLast_r[1] && externalLine1
      |=> reqFlags_r[MIC_BIT_LINE1])
      else $error("rising edge on line 1 missed");

   AST_NO_SEEN_NO_REQ: assert property (@(posedge clk) disable iff (rst) // [R16]
      state_r == MIC_IDLE && !(pollStrobe && !globalMask && |seenReq)
      |=> !serviceReq)
      else $error("request raised without an enabled pending source");

   AST_VEC_MAP: assert property (@(posedge clk) disable iff (rst) // [R1]
      $rose(serviceReq) && !softBreak
      |=> serviceVector == MIC_VEC_FIRST - 16'(2 * srcSel_r))
      else $error("handler vector does not match the source");

   AST_BRK_MASK: assert property (@(posedge clk) disable iff (rst) // [R1]
      softBreak |=> globalMask && serviceVector == MIC_VEC_BRK)
      else $error("break did not mask or point at its vector");

   AST_MASK_IN_ACK: assert property (@(posedge clk) disable iff (rst) // [R17]
      state_r == MIC_ACK |-> globalMask)
      else $error("mask clear while a service is taken");

   AST_SRC_STABLE: assert property (@(posedge clk) disable iff (rst) // [R16]
      serviceReq |=> $stable(srcSel_r))
      else $error("selected source moved during a request");

   AST_RD_EN_C7: assert property (@(posedge clk) disable iff (rst) // [R19]
      $past(regRead) && $past(regAddr) == MIC_OFF_EN_C |-> !regRdata[7])
      else $error("reserved enable bit read as one");

   AST_RD_EN_A: assert property (@(posedge clk) disable iff (rst) // [R11]
      $past(regRead) && $past(regAddr) == MIC_OFF_EN_A
      |-> regRdata == $past(enFlags_r[7:0]))
      else $error("enable bank a read back wrong");

   AST_RD_REQ_A: assert property (@(posedge clk) disable iff (rst) // [R12]
      $past(regRead) && $past(regAddr) == MIC_OFF_REQ_A
      |-> regRdata == $past(reqFlags_r[7:0]))
      else $error("request bank a read back wrong");

   COV_SERVICE: cover property (@(posedge clk) disable iff (rst)
      serviceReq ##[1:4] serviceAck);
   COV_RISE_LINE0: cover property (@(posedge clk) disable iff (rst)
      edgePol_r[0] && lineEdge[0]);
   COV_SET_CLR_SAME: cover property (@(posedge clk) disable iff (rst)
      swClr[0] && evAll[0]);
   COV_BREAK: cover property (@(posedge clk) disable iff (rst)
      softBreak ##1 globalMask);

endmodule : mic_ctrl
`default_nettype wire

/* test/mic_core_model.sv */
// mic_core_model: processor core stand-in that acknowledges service requests
`timescale 1ns/1ps
`default_nettype none
module mic_core_model
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       serviceReq,
   input  wire logic [3:0] ackDelay,
   output logic            serviceAck
);
   logic [3:0] waitCnt_r;
   ////////////////////////////////////////////////////////////////////////////
   // one ack per request; the ack cycle itself is skipped since req drops after it
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         waitCnt_r  <= 4'h0;
         serviceAck <= 1'b0;
      end
      else
      begin
         serviceAck <= 1'b0;
         waitCnt_r  <= 4'h0;
         if (serviceReq && !serviceAck)
         begin
            waitCnt_r <= waitCnt_r + 4'h1;
            if (waitCnt_r == ackDelay)
               serviceAck <= 1'b1;
         end
      end
   end
endmodule : mic_core_model
`default_nettype wire

/* test/mic_ctrl_bench.sv */
// mic_ctrl_bench: self-checking bench of the interrupt control unit
`timescale 1ns/1ps
`default_nettype none
module mic_ctrl_bench import mic_pkg::*;;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  regAddr = 8'h00;
   logic [7:0]  regWdata = 8'h00;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [7:0]  regRdata;
   logic [22:0] srcEvent = 23'h0;
   logic        externalLine0 = 1'b1;
   logic        externalLine1 = 1'b1;
   logic        pollStrobe = 1'b0;
   logic        serviceAck;
   logic        returnFromIrq = 1'b0;
   logic        softBreak = 1'b0;
   logic        serviceReq;
   logic [4:0]  serviceSrc;
   logic [15:0] serviceVector;
   logic        globalMask;
   logic        resetVectorValid;
   logic [15:0] resetVector;
   logic [4:0]  resetPriority;
   logic [3:0]  ackDelay = 4'h3;
   int          errorCnt = 0;
   int          checkCount = 0;
   logic [23:0] rows [7] = '{24'h02ff00, 24'h04ff00, 24'h05a5a5, 24'h065a5a,
                             24'h07ff7f, 24'h370303, 24'h10ff00};

   always #12.5 clk = ~clk;

   mic_ctrl i_mic_ctrl (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .srcEvent(srcEvent),
      .externalLine0(externalLine0), .externalLine1(externalLine1), .pollStrobe(pollStrobe),
      .serviceAck(serviceAck), .softBreak(softBreak), .returnFromIrq(returnFromIrq),
      .serviceReq(serviceReq), .serviceSrc(serviceSrc), .serviceVector(serviceVector),
      .globalMask(globalMask), .resetVectorValid(resetVectorValid),
      .resetVector(resetVector), .resetPriority(resetPriority));

   mic_core_model i_mic_core_model (.clk(clk), .rst(rst), .serviceReq(serviceReq),
      .ackDelay(ackDelay), .serviceAck(serviceAck));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic completeRun();
      $display("checks %0d errors %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : completeRun

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr

   // data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk("regRdata", {8'h00, regRdata}, {8'h00, exp});
   endtask : rd

   task automatic ev(input int n);
      @(posedge clk);
      srcEvent[n] <= 1'b1;
      @(posedge clk);
      srcEvent <= 23'h0;
   endtask : ev

   // one-cycle strobe on {softBreak, returnFromIrq, pollStrobe}
   task automatic pulse(input logic [2:0] sel);
      @(posedge clk);
      {softBreak, returnFromIrq, pollStrobe} <= sel;
      @(posedge clk);
      {softBreak, returnFromIrq, pollStrobe} <= 3'b000;
   endtask : pulse

   // unmask, poll, wait for the request and the model's ack under a bound
   task automatic service(input int src, input logic [3:0] dly);
      int n;
      ackDelay <= dly;
      pulse(3'b010);
      #1 chk("globalMask", {15'h0, globalMask}, 16'h0000);
      pulse(3'b001);
      n = 0;
      #1;
      while (serviceReq !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk("serviceSrc", {11'h0, serviceSrc}, 16'(src));
      @(posedge clk);
      #1 chk("serviceVector", serviceVector, 16'hfff8 - 16'(2 * src));
      while (serviceReq === 1'b1 && n < 40)
      begin
         @(posedge clk);
         #1 n++;
      end
      #1 chk("globalMask", {15'h0, globalMask}, 16'h0001);
      repeat (2) @(posedge clk);
   endtask : service
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4000) @(posedge clk);
      errorCnt++;
      completeRun();
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1 chk("serviceVector", serviceVector, 16'hfffa);
      chk("globalMask", {15'h0, globalMask}, 16'h0001);
      foreach (rows[i])
         rd(rows[i][23:16], 8'h00);
      chk("resetVectorValid", {15'h0, resetVectorValid}, 16'h0001);
      chk("resetVector", resetVector, 16'hfffa);
      chk("resetPriority", {11'h0, resetPriority}, 16'h0003);
      foreach (rows[i])
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      for (int a = 5; a < 8; a++)
         wr(8'(a), 8'h00);
      wr(8'h37, 8'h00);
      // events latch with the enable off and survive a write of ones
      ev(8);
      rd(8'h03, 8'h01);
      wr(8'h03, 8'hff);
      rd(8'h03, 8'h01);
      wr(8'h03, 8'hfe);
      rd(8'h03, 8'h00);
      // line 1 on rising edge, line 0 on falling edge
      wr(8'h37, 8'h02);
      @(posedge clk) externalLine0 <= 1'b0;
      @(posedge clk) externalLine1 <= 1'b0;
      rd(8'h02, 8'h04);
      @(posedge clk) externalLine1 <= 1'b1;
      @(posedge clk) externalLine0 <= 1'b1;
      rd(8'h02, 8'h0c);
      wr(8'h02, 8'h00);
      // poll while masked must stay quiet
      ev(19);
      ev(6);
      wr(8'h07, 8'h08);
      pulse(3'b001);
      repeat (3) @(posedge clk);
      #1 chk("serviceReq", {15'h0, serviceReq}, 16'h0000);
      service(19, 4'h3);
      rd(8'h04, 8'h00);
      rd(8'h02, 8'h40);
      wr(8'h05, 8'h40);
      service(6, 4'h0);
      rd(8'h02, 8'h00);
      // break sets the mask and shows its own vector for one cycle
      pulse(3'b010);
      pulse(3'b100);
      #1 chk("serviceVector", serviceVector, 16'hffca);
      chk("globalMask", {15'h0, globalMask}, 16'h0001);
      // reset in mid-run with state loaded and the mask open
      wr(8'h05, 8'hff);
      ev(0);
      pulse(3'b010);
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      #1 chk("serviceVector", serviceVector, 16'hfffa);
      chk("globalMask", {15'h0, globalMask}, 16'h0001);
      rd(8'h02, 8'h00);
      rd(8'h05, 8'h00);
      completeRun();
   end
endmodule : mic_ctrl_bench
`default_nettype wire
